// ---- verilog/lbq_arbiter.sv ----
// Request/grant arbiter with queue status and spare status output
`default_nettype none
module lbq_arbiter (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration strap, low selects arbitration mode
  input wire logic config_strap,
  // High-priority line, open-drain style
  input wire logic arb_line_high_prio_in,
  output logic arb_line_high_prio_out,
  output logic arb_line_high_prio_oe_n,
  // Low-priority line
  input wire logic arb_line_low_prio_in,
  output logic arb_line_low_prio_out,
  output logic arb_line_low_prio_oe_n,
  // Bus cycle state from the bus sequencer
  input wire logic bus_state_first,
  input wire logic bus_state_second,
  input wire logic bus_state_last,
  input wire logic bus_idle,
  input wire logic cyc_low_byte,
  input wire logic cyc_first_inta,
  input wire logic lock_active,
  input wire logic cycle_pending,
  // Bus control to the sequencer
  output logic bus_float,
  output logic cycle_inhibit,
  output logic retake_first,
  // Queue operation from the prefetch unit
  input wire logic [1:0] queue_op,
  output logic queue_code_hi,
  output logic queue_code_lo,
  // Spare status pin
  output logic spare_out,
  output logic spare_oe_n,
  output logic spare_weak
);
  import lbq_pkg::*;

  logic max_mode;
  logic req_hi;
  logic req_lo;
  logic pend_hi_reg;
  logic pend_hi_next;
  logic pend_lo_reg;
  logic pend_lo_next;
  logic early_reg;
  logic early_next;
  logic who_lo_reg;
  logic eligible;
  logic boundary;
  logic take_grant;
  logic pick_lo;
  logic rel_seen;
  logic [1:0] qcode_reg;
  lbq_state_t st_reg;
  lbq_state_t st_next;

  assign max_mode = ~config_strap; // RULE_01

  lbq_pulse_rx u_rx_hi (
    .clk(clk),
    .srst(srst),
    .line_in(arb_line_high_prio_in),
    .pulse(req_hi)
  );
  lbq_pulse_rx u_rx_lo (
    .clk(clk),
    .srst(srst),
    .line_in(arb_line_low_prio_in),
    .pulse(req_lo)
  );

  // Only a request pending by the second state counts for this cycle;
  // a later one waits for the next cycle end
  assign early_next = (bus_state_first | bus_state_second) & (pend_hi_next | pend_lo_next)
                      | early_reg & ~bus_state_last; // RULE_09
  assign eligible = (early_reg | bus_idle) & ~cyc_low_byte & ~cyc_first_inta
                    & ~lock_active; // RULE_09
  // Idle bus grants at once; busy bus waits for a cycle end
  assign boundary = bus_idle | bus_state_last | bus_state_first; // RULE_10
  assign take_grant = (st_reg == LBQ_ST_OWN) & (pend_hi_reg | pend_lo_reg)
                      & boundary & eligible & max_mode; // RULE_04 RULE_16
  assign pick_lo = ~pend_hi_reg; // RULE_15
  assign rel_seen = who_lo_reg ? req_lo : req_hi;

  // Pending requests held until granted
  assign pend_hi_next = max_mode & (pend_hi_reg & ~(take_grant & ~pick_lo)
                        | req_hi & (st_reg == LBQ_ST_OWN)); // RULE_03 RULE_16
  assign pend_lo_next = max_mode & (pend_lo_reg & ~(take_grant & pick_lo)
                        | req_lo & (st_reg == LBQ_ST_OWN)); // RULE_16

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      LBQ_ST_OWN: if (take_grant) st_next = LBQ_ST_GRANT;
      LBQ_ST_GRANT: st_next = LBQ_ST_HELD;
      LBQ_ST_HELD: if (rel_seen) st_next = LBQ_ST_RETAKE; // RULE_06 RULE_07
      LBQ_ST_RETAKE: st_next = LBQ_ST_GAP;
      LBQ_ST_GAP: st_next = LBQ_ST_OWN; // RULE_08
      default: st_next = LBQ_ST_OWN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= LBQ_ST_OWN;
      pend_hi_reg <= 1'b0;
      pend_lo_reg <= 1'b0;
      early_reg <= 1'b0;
      who_lo_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      pend_hi_reg <= pend_hi_next;
      pend_lo_reg <= pend_lo_next;
      early_reg <= early_next & ~bus_state_last;
      if (take_grant) begin
        who_lo_reg <= pick_lo;
      end
    end
  end

  // Grant pulse drives low for one clock; otherwise release to hold-high
  assign arb_line_high_prio_out = 1'b0;
  assign arb_line_low_prio_out = 1'b0;
  assign arb_line_high_prio_oe_n = ~((st_reg == LBQ_ST_GRANT) & ~who_lo_reg); // RULE_04 RULE_08
  assign arb_line_low_prio_oe_n = ~((st_reg == LBQ_ST_GRANT) & who_lo_reg); // RULE_04

  // Bus floats from the grant clock until the re-take clock
  assign bus_float = (st_reg == LBQ_ST_GRANT) | (st_reg == LBQ_ST_HELD); // RULE_04
  assign cycle_inhibit = bus_float; // RULE_05
  assign retake_first = (st_reg == LBQ_ST_RETAKE) & ~cycle_pending; // RULE_06

  // Queue code registered one clock after the operation
  always_ff @(posedge clk) begin
    if (srst) begin
      qcode_reg <= LBQ_Q_NOP;
    end else begin
      qcode_reg <= max_mode ? queue_op : LBQ_Q_NOP; // RULE_11 RULE_12
    end
  end
  assign queue_code_hi = qcode_reg[1]; // RULE_13
  assign queue_code_lo = qcode_reg[0]; // RULE_13

  assign spare_out = 1'b1; // RULE_14
  assign spare_oe_n = bus_float; // RULE_14
  assign spare_weak = bus_float; // RULE_14

  property p_grant_one;
    @(posedge clk) disable iff (srst)
    (st_reg == LBQ_ST_GRANT) |=> (st_reg == LBQ_ST_HELD);
  endproperty
  a_grant_one: assert property (p_grant_one) else $error("grant longer than one clock"); // RULE_04
  property p_no_cycle;
    @(posedge clk) disable iff (srst)
    (st_reg == LBQ_ST_HELD) |-> cycle_inhibit && bus_float;
  endproperty
  a_no_cycle: assert property (p_no_cycle) else $error("cycle allowed while granted"); // RULE_05
  property p_retake;
    @(posedge clk) disable iff (srst)
    (st_reg == LBQ_ST_HELD) && rel_seen |=> !bus_float;
  endproperty
  a_retake: assert property (p_retake) else $error("bus not re-taken"); // RULE_06
  property p_gap;
    @(posedge clk) disable iff (srst)
    (st_reg == LBQ_ST_RETAKE) |=> (st_reg == LBQ_ST_GAP) ##1 !bus_float;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle clock after exchange"); // RULE_08
  property p_elig;
    @(posedge clk) disable iff (srst)
    take_grant |-> !lock_active && !cyc_low_byte && !cyc_first_inta;
  endproperty
  a_elig: assert property (p_elig) else $error("ineligible grant"); // RULE_09
  property p_idle;
    @(posedge clk) disable iff (srst)
    (st_reg == LBQ_ST_OWN) && pend_hi_reg && bus_idle && !lock_active && max_mode
    |=> !arb_line_high_prio_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bus not released"); // RULE_10
  // Reset clock excluded: the code register is cleared there
  property p_qcode;
    @(posedge clk) disable iff (srst)
    max_mode && !srst |=> {queue_code_hi, queue_code_lo} == $past(queue_op);
  endproperty
  a_qcode: assert property (p_qcode) else $error("queue code wrong"); // RULE_12
  property p_prio;
    @(posedge clk) disable iff (srst)
    take_grant && pend_hi_reg |=> !who_lo_reg;
  endproperty
  a_prio: assert property (p_prio) else $error("low line beat high line"); // RULE_15
  property p_spare;
    @(posedge clk) disable iff (srst)
    spare_out && (spare_oe_n == bus_float);
  endproperty
  a_spare: assert property (p_spare) else $error("spare status wrong"); // RULE_14
  property p_mode;
    @(posedge clk) disable iff (srst)
    config_strap |-> !take_grant;
  endproperty
  a_mode: assert property (p_mode) else $error("grant outside arbitration mode"); // RULE_01

  c_grant_hi: cover property (@(posedge clk) disable iff (srst)
    !arb_line_high_prio_oe_n);
  c_grant_lo: cover property (@(posedge clk) disable iff (srst)
    !arb_line_low_prio_oe_n);
  c_exchange: cover property (@(posedge clk) disable iff (srst)
    (st_reg == LBQ_ST_RETAKE) ##1 (st_reg == LBQ_ST_GAP));
endmodule
`default_nettype wire

// ---- include/lbq_pkg.sv ----
// Package of constants and types for the local-bus arbiter and queue tracker
// Behaviour
// RULE_01 - Arbitration pins active only when strap low
// RULE_02 - Weak hold-high keeps idle lines inactive
// RULE_03 - Requester drives one-clock low request pulse
// RULE_04 - One-clock grant in last/first state, float bus
// RULE_05 - No bus cycle during grant sequence
// RULE_06 - Release pulse; re-take bus next clock
// RULE_07 - Hand-over is request, grant, release
// RULE_08 - Pulses low; idle clock after exchange
// RULE_09 - Grant mid-cycle only when four conditions hold
// RULE_10 - Idle bus released during next clock
// RULE_11 - Queue code encoding of four operations
// RULE_12 - Queue code appears the following clock
// RULE_13 - Queue code always driven, never floats
// RULE_14 - Spare status high, weak high when granted
// RULE_15 - High-priority line wins simultaneous requests
// RULE_16 - Ineligible request stays pending until eligible
`default_nettype none
package lbq_pkg;
  localparam logic [1:0] LBQ_Q_NOP = 2'h0;
  localparam logic [1:0] LBQ_Q_FIRST = 2'h1;
  localparam logic [1:0] LBQ_Q_EMPTY = 2'h2;
  localparam logic [1:0] LBQ_Q_NEXT = 2'h3;
  localparam int LBQ_IDLE_CLKS = 1;
  typedef enum logic [4:0] {
    LBQ_ST_OWN = 5'h01,
    LBQ_ST_GRANT = 5'h02,
    LBQ_ST_HELD = 5'h04,
    LBQ_ST_RETAKE = 5'h08,
    LBQ_ST_GAP = 5'h10
  } lbq_state_t;
endpackage
`default_nettype wire

// ---- verilog/lbq_pulse_rx.sv ----
// Falling-edge pulse detector for one request/grant line
`default_nettype none
module lbq_pulse_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Line level and result
  input wire logic line_in,
  output logic pulse
);
  logic prev_reg;
  // Undriven line reads high through the hold-high, so no pulse
  assign pulse = prev_reg & ~line_in; // RULE_02
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= line_in;
    end
  end
endmodule
`default_nettype wire

// ---- tb/lbq_master_model.sv ----
// Behavioural second bus master on one request/grant line
`default_nettype none
module lbq_master_model (
  // Clock and resolved line level
  input wire logic clk,
  input wire logic line_lvl,
  // High pulls the line low
  output logic drv_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial drv_low = 1'b0;
  task automatic pulse();
    @(posedge clk) drv_low <= 1'b1;
    @(posedge clk) drv_low <= 1'b0;
  endtask
  // Request, wait for grant, hold the bus, release; n=30 means no grant
  task automatic hand_over(input int hold, output int n);
    pulse();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (line_lvl !== 1'b0 && n < 30);
    if (n < 30) begin
      repeat (hold) @(posedge clk);
      pulse();
    end
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/lbq_arbiter_test.sv ----
// Self-checking bench for the request/grant arbiter and queue status
`default_nettype none
module lbq_arbiter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, strap, lock, low_byte, inta, run, pend, quiet, flt_q;
  logic [1:0] qop, qop_d, ph;
  logic [31:0] seed = 32'h3166;
  logic h_out, h_oe_n, l_out, l_oe_n, d0, d1, qhi, qlo, flt, inh, rtf, sp, sp_oe_n, sp_wk;
  int err_total = 0, n_compared = 0, cyc = 0, flt_n = 0, w0, w1;
  // Pull-up wins whenever nobody drives low
  wire line0 = !((!h_oe_n && !h_out) || d0);
  wire line1 = !((!l_oe_n && !l_out) || d1);
  lbq_arbiter dut_u (.clk(clk), .srst(srst), .config_strap(strap),
    .arb_line_high_prio_in(line0), .arb_line_high_prio_out(h_out),
    .arb_line_high_prio_oe_n(h_oe_n), .arb_line_low_prio_in(line1),
    .arb_line_low_prio_out(l_out), .arb_line_low_prio_oe_n(l_oe_n),
    .bus_state_first(run && ph == 2'h0), .bus_state_second(run && ph == 2'h1),
    .bus_state_last(run && ph == 2'h3), .bus_idle(!run), .cyc_low_byte(low_byte),
    .cyc_first_inta(inta), .lock_active(lock), .cycle_pending(pend), .bus_float(flt),
    .cycle_inhibit(inh), .retake_first(rtf), .queue_op(qop), .queue_code_hi(qhi),
    .queue_code_lo(qlo), .spare_out(sp), .spare_oe_n(sp_oe_n), .spare_weak(sp_wk));
  lbq_master_model m0_u (.clk(clk), .line_lvl(line0), .drv_low(d0));
  lbq_master_model m1_u (.clk(clk), .line_lvl(line1), .drv_low(d1));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] a, b;
    a = v ^ (v << 13);
    b = a ^ (a >> 17);
    return b ^ (b << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    seed <= xs(seed);
    qop <= seed[1:0];
    pend <= seed[7];
    qop_d <= qop;
    ph <= ph + 2'h1;
    quiet <= srst | strap;
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      complete_run();
    end
  end
  // Queue code is last clock's operation; float and spare track each other;
  // the first unfloated clock is the re-take clock
  always @(negedge clk) begin
    if (flt === 1'b1)
      flt_n++;
    flt_q <= flt;
    if (!(srst || strap || quiet)) begin
      chk({qhi, qlo}, qop_d);
      chk(rtf, flt_q === 1'b1 && flt === 1'b0 && pend === 1'b0);
      chk(inh, flt);
      chk({sp, sp_oe_n, sp_wk}, {1'b1, flt, flt});
    end
  end
  initial begin
    {srst, strap, lock, low_byte, inta, run, pend, quiet, qop, qop_d, ph} = 14'h2000;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    m0_u.hand_over(5, w0);
    chk(w0, 2);
    chk(flt_n, 8);
    $display("test idle grant done");
    fork
      m0_u.hand_over(3, w0);
      m1_u.hand_over(3, w1);
    join
    chk(w0, 2);
    chk(w1 >= 10, 1);
    $display("test priority done");
    run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      {lock, low_byte, inta} <= 3'h1 << i;
      fork
        m1_u.hand_over(2, w1);
        begin
          repeat (12) @(posedge clk);
          {lock, low_byte, inta} <= 3'h0;
        end
      join
      chk(w1 inside {[11:24]}, 1);
    end
    // Request in the third state misses this cycle end, waits for the next
    do @(posedge clk); while (ph != 2'h0);
    m1_u.hand_over(2, w1);
    chk(w1, 6);
    run <= 1'b0;
    $display("test blocked cycles done");
    strap <= 1'b1;
    m0_u.hand_over(2, w0);
    chk(w0, 30);
    srst <= 1'b1;
    strap <= 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test strap off done");
    complete_run();
  end
endmodule
`default_nettype wire
